// file: hdl/vlmirq_top.sv
// module: axi4-lite register file and interrupt of the level monitor
//
// Functional notes
// - crossing select: 0 fall, 1 rise, 2 both
// - enable bit 0 gates the interrupt request
// - matching crossing sets the monitor flag
// - flag only sets while detector enabled
// - status reads 1 below threshold, 0 above
// - request high while flag and enable set
// - margin select: 5, 15, 25 percent
//
// Chosen here: the AXI4-Lite slave port.
`default_nettype none
module vlmirq_top (
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [31:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [31:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // monitor side
  input wire logic below_threshold_raw,
  input wire logic brownout_detector_enable,
  output logic [1:0] monitor_margin_select,
  output logic irq
);
  import vlmirq_pkg::*;

  // ********************************************************************
  // address decode
  // ********************************************************************
  // full-word compare: aliases above the map are refused, not folded
  function automatic logic is_reg(input logic [31:0] addr,
                                  input logic [7:0] idx);
    logic hit;
    hit = (addr == {22'h000000, idx, 2'b00});
    return hit;
  endfunction

  // ********************************************************************
  // state
  // ********************************************************************
  logic sync1_q; // first stage, read only by sync2_q
  logic sync2_q; // synchronised below-threshold level
  logic ie_q; // monitor_irq_enable
  logic ie_d;
  logic [1:0] cfg_q; // crossing_select
  logic [1:0] cfg_d;
  logic [1:0] margin_q; // monitor_margin_select
  logic [1:0] margin_d;
  logic flag_q; // monitor_irq_flag
  logic flag_d;
  logic irq_q; // registered request
  logic awready_q; // write address and data taken together
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic arready_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [31:0] rdata_q;

  // ********************************************************************
  // write channel decode
  // ********************************************************************
  logic wr_go_w; // both write channels offered, slave idle
  logic wr_fire_w; // write lands at this edge
  logic wr_lane0_w; // low byte lane enabled
  logic hit_margin_w;
  logic hit_ctrl_w;
  logic hit_flags_w;
  logic hit_stat_w;
  logic wr_mapped_w;
  logic wr_margin_w;
  logic wr_ctrl_w;
  logic wr_flags_w;
  logic flag_clr_w;
  logic [1:0] new_margin_w;
  logic margin_ok_w; // written code is not reserved

  assign wr_go_w = s_axi_awvalid & s_axi_wvalid & ~awready_q & ~bvalid_q;
  assign wr_fire_w = awready_q & s_axi_awvalid & s_axi_wvalid;
  assign wr_lane0_w = s_axi_wstrb[0];
  assign hit_margin_w = is_reg(s_axi_awaddr, IDX_MARGIN_CTRL);
  assign hit_ctrl_w = is_reg(s_axi_awaddr, IDX_IRQ_CTRL);
  assign hit_flags_w = is_reg(s_axi_awaddr, IDX_IRQ_FLAGS);
  assign hit_stat_w = is_reg(s_axi_awaddr, IDX_LEVEL_STAT);
  assign wr_mapped_w = hit_margin_w | hit_ctrl_w | hit_flags_w | hit_stat_w;
  assign wr_margin_w = wr_fire_w & hit_margin_w & wr_lane0_w;
  assign wr_ctrl_w = wr_fire_w & hit_ctrl_w & wr_lane0_w;
  assign wr_flags_w = wr_fire_w & hit_flags_w & wr_lane0_w;
  assign new_margin_w = s_axi_wdata[MARGIN_MSB:MARGIN_LSB];
  // a reserved margin code would leave the analog level undefined
  assign margin_ok_w = (new_margin_w == MARGIN_5PCT) |
                       (new_margin_w == MARGIN_15PCT) |
                       (new_margin_w == MARGIN_25PCT);

  // ********************************************************************
  // register next values
  // ********************************************************************
  vlmirq_mon_if mon_if ();

  assign margin_d = (wr_margin_w & margin_ok_w) ?
                    new_margin_w : margin_q;
  assign ie_d = wr_ctrl_w ? s_axi_wdata[IE_BIT] : ie_q;
  assign cfg_d = wr_ctrl_w ?
                 s_axi_wdata[CFG_MSB:CFG_LSB] : cfg_q;
  // only a one clears; a zero leaves the flag alone
  assign flag_clr_w = wr_flags_w & s_axi_wdata[FLAG_BIT];
  // a crossing in the clearing cycle wins, so no event is lost
  assign flag_d = (flag_q & ~flag_clr_w) |
                  mon_if.crossing_event;

  // ********************************************************************
  // crossing detector
  // ********************************************************************
  assign mon_if.below_level = sync2_q;
  assign mon_if.detector_on = brownout_detector_enable;
  assign mon_if.crossing_select = cfg_q;

  vlmirq_edge u_edge (
    .aclk(aclk),
    .aresetn(aresetn),
    .mon(mon_if.mon)
  );

  // ********************************************************************
  // read channel decode
  // ********************************************************************
  logic rd_go_w;
  logic rd_fire_w;
  logic rd_margin_w;
  logic rd_ctrl_w;
  logic rd_flags_w;
  logic rd_stat_w;
  logic rd_mapped_w;
  logic [31:0] rd_data_w;

  assign rd_go_w = s_axi_arvalid & ~arready_q & ~rvalid_q;
  assign rd_fire_w = arready_q & s_axi_arvalid;
  assign rd_margin_w = is_reg(s_axi_araddr, IDX_MARGIN_CTRL);
  assign rd_ctrl_w = is_reg(s_axi_araddr, IDX_IRQ_CTRL);
  assign rd_flags_w = is_reg(s_axi_araddr, IDX_IRQ_FLAGS);
  assign rd_stat_w = is_reg(s_axi_araddr, IDX_LEVEL_STAT);
  assign rd_mapped_w = rd_margin_w | rd_ctrl_w | rd_flags_w | rd_stat_w;
  // status is shown even with the detector off; software must ignore it
  assign rd_data_w =
    rd_margin_w ? {30'h00000000, margin_q} :
    rd_ctrl_w ? {29'h00000000, cfg_q, ie_q} :
    rd_flags_w ? {31'h00000000, flag_q} :
    rd_stat_w ? {31'h00000000, sync2_q} :
    32'h00000000;

  // ********************************************************************
  // processes
  // ********************************************************************
  // two-stage synchroniser for the comparator pin
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end else begin
      sync1_q <= below_threshold_raw;
      sync2_q <= sync1_q;
    end
  end

  // control and flag registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      margin_q <= RST_MARGIN_CTRL[MARGIN_MSB:MARGIN_LSB];
      ie_q <= RST_IRQ_CTRL[IE_BIT];
      cfg_q <= RST_IRQ_CTRL[CFG_MSB:CFG_LSB];
      flag_q <= RST_IRQ_FLAGS[FLAG_BIT];
    end else begin
      margin_q <= margin_d;
      ie_q <= ie_d;
      cfg_q <= cfg_d;
      flag_q <= flag_d;
    end
  end

  // request stays high until the flag is cleared or masked
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= flag_q & ie_q;
    end
  end

  // write handshake: ready pulses one cycle, then response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else begin
      awready_q <= wr_go_w;
      if (wr_fire_w) begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_mapped_w ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // read handshake: data captured at the address edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rresp_q <= RESP_OKAY;
      rdata_q <= 32'h00000000;
    end else begin
      arready_q <= rd_go_w;
      if (rd_fire_w) begin
        rvalid_q <= 1'b1;
        rresp_q <= rd_mapped_w ? RESP_OKAY : RESP_SLVERR;
        rdata_q <= rd_data_w;
      end else if (rvalid_q && s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // ********************************************************************
  // outputs
  // ********************************************************************
  assign s_axi_awready = awready_q;
  assign s_axi_wready = awready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;
  assign monitor_margin_select = margin_q;
  assign irq = irq_q;
endmodule
`default_nettype wire

// file: hdl/vlmirq_pkg.sv
// package: register map, field layout and codes of the level monitor irq
`default_nettype none
package vlmirq_pkg;
  // ********************************************************************
  // register indices (byte address is four times the index)
  // ********************************************************************
  localparam logic [7:0] IDX_MARGIN_CTRL = 8'h08; // margin select reg
  localparam logic [7:0] IDX_IRQ_CTRL = 8'h09; // enable and crossing select
  localparam logic [7:0] IDX_IRQ_FLAGS = 8'h0A; // sticky monitor flag
  localparam logic [7:0] IDX_LEVEL_STAT = 8'h0B; // below-threshold status

  // ********************************************************************
  // field positions
  // ********************************************************************
  localparam int IE_BIT = 0; // monitor_irq_enable
  localparam int CFG_LSB = 1; // crossing_select low bit
  localparam int CFG_MSB = 2; // crossing_select high bit
  localparam int FLAG_BIT = 0; // monitor_irq_flag
  localparam int STAT_BIT = 0; // below_threshold_status
  localparam int MARGIN_LSB = 0; // monitor_margin_select low bit
  localparam int MARGIN_MSB = 1; // monitor_margin_select high bit

  // ********************************************************************
  // reset values
  // ********************************************************************
  localparam logic [7:0] RST_MARGIN_CTRL = 8'h00;
  localparam logic [7:0] RST_IRQ_CTRL = 8'h00;
  localparam logic [7:0] RST_IRQ_FLAGS = 8'h00;
  localparam logic [7:0] RST_LEVEL_STAT = 8'h00;

  // ********************************************************************
  // codes
  // ********************************************************************
  localparam logic [1:0] CROSS_FALL = 2'h0; // supply falls through level
  localparam logic [1:0] CROSS_RISE = 2'h1; // supply rises through level
  localparam logic [1:0] CROSS_BOTH = 2'h2; // either direction
  localparam logic [1:0] MARGIN_5PCT = 2'h0; // 5% above brownout level
  localparam logic [1:0] MARGIN_15PCT = 2'h1; // 15% above brownout level
  localparam logic [1:0] MARGIN_25PCT = 2'h2; // 25% above brownout level
  localparam logic [1:0] RESP_OKAY = 2'h0; // axi okay
  localparam logic [1:0] RESP_SLVERR = 2'h2; // axi slave error

  // trigger decode: reserved select codes never trigger
  function automatic logic crossing_match(input logic [1:0] sel,
                                          input logic fall,
                                          input logic rise);
    logic hit;
    hit = 1'b0;
    case (sel)
      CROSS_FALL: hit = fall;
      CROSS_RISE: hit = rise;
      CROSS_BOTH: hit = fall | rise;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction
endpackage
`default_nettype wire

// file: hdl/vlmirq_mon_if.sv
// interface: level and crossing signals between register file and detector
`default_nettype none
interface vlmirq_mon_if;
  logic below_level; // synchronised comparator level, 1 = below
  logic detector_on; // brownout detector enabled
  logic [1:0] crossing_select; // trigger direction
  logic crossing_event; // one-cycle pulse on a matching crossing
  modport mon (
    input below_level,
    input detector_on,
    input crossing_select,
    output crossing_event
  );
  modport ctl (
    output below_level,
    output detector_on,
    output crossing_select,
    input crossing_event
  );
endinterface
`default_nettype wire

// file: hdl/vlmirq_edge.sv
// module: crossing detector of the voltage level monitor
`default_nettype none
module vlmirq_edge (
  input wire logic aclk,
  input wire logic aresetn,
  vlmirq_mon_if.mon mon
);
  import vlmirq_pkg::*;

  // ********************************************************************
  // edge detection
  // ********************************************************************
  logic prev_q; // level seen last cycle
  logic prev_d;
  logic fall_w; // supply dropped below the level
  logic rise_w; // supply came back above the level
  logic hit_w;

  // tracks the level even while off, so enabling gives no false edge
  assign prev_d = mon.below_level;
  assign fall_w = mon.below_level & ~prev_q;
  assign rise_w = ~mon.below_level & prev_q;
  assign hit_w = crossing_match(mon.crossing_select,
                                fall_w, rise_w);
  // no event while the detector is off, so the flag holds
  assign mon.crossing_event = hit_w & mon.detector_on;

  // previous-level register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= prev_d;
    end
  end
endmodule
`default_nettype wire

// file: testbench/vlmirq_asserts.sv
// checker: concurrent properties on the level monitor irq top ports
`default_nettype none
module vlmirq_asserts (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic brownout_detector_enable,
  input wire logic [1:0] monitor_margin_select,
  input wire logic irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ****************************
  // sequences
  // ****************************
  // fresh read request with no answer pending
  sequence s_rd_req;
    $rose(s_axi_arvalid) && !s_axi_rvalid;
  endsequence
  // a write landed two edges back (flag or enable changed)
  sequence s_wr_land;
    $past(s_axi_awready, 2);
  endsequence
  // ****************************
  // properties
  // ****************************
  a_aw_w_pair: assert property (s_axi_awready |-> s_axi_wready
    ##1 (!s_axi_awready && !s_axi_wready))
    else $error("write ready not a joint one-cycle pulse");
  a_resp_after: assert property (s_axi_awready |=> s_axi_bvalid)
    else $error("no write response after handshake");
  a_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("bvalid held after handshake");
  a_ar_pulse: assert property (s_axi_arready |=> !s_axi_arready)
    else $error("arready longer than one cycle");
  a_rd_latency: assert property (s_rd_req |-> ##2 s_axi_rvalid)
    else $error("read answer late");
  a_margin_src: assert property (
    $changed(monitor_margin_select) |-> $past(s_axi_awready))
    else $error("margin changed without write");
  a_irq_held: assert property ($fell(irq) |-> s_wr_land)
    else $error("irq dropped without write");
  a_irq_cause: assert property (
    $rose(irq) |-> s_wr_land or $past(brownout_detector_enable, 2))
    else $error("irq rose with detector off");
endmodule
bind vlmirq_top vlmirq_asserts u_chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid),
  .brownout_detector_enable(brownout_detector_enable),
  .monitor_margin_select(monitor_margin_select), .irq(irq));
`default_nettype wire

// file: testbench/vlmirq_test.sv
// testbench: self-checking run of the level monitor irq top
`default_nettype none
module vlmirq_test;
  timeunit 1ns;
  timeprecision 1ps;
  import vlmirq_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, raw, den;
  logic awready, wready, bvalid, arready, rvalid, irq, e, ie, fall;
  logic [31:0] awaddr, wdata, araddr, rdata, d;
  logic [1:0] bresp, rresp, margin, mexp, sel;
  int err_total = 0; // mismatches
  int n_checks = 0; // comparisons made
  int seed = 32'h5364; // fixed so runs repeat
  int cyc = 0; // timeout counter
  int i;
  vlmirq_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .below_threshold_raw(raw), .brownout_detector_enable(den),
    .monitor_margin_select(margin), .irq(irq));
  // ****************************
  // helpers
  // ****************************
  // bench's own trigger decode; reserved codes never fire
  function automatic logic exp_hit(input logic [1:0] s, input logic f);
    case (s)
      2'h0: return f;
      2'h1: return !f;
      2'h2: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction
  task automatic chk(input string nm, input logic [31:0] ex,
                     input logic [31:0] g);
    n_checks++;
    if (g !== ex) begin
      err_total++;
      $display("unexpected %s exp %h got %h", nm, ex, g);
    end
  endtask
  // one write; both channels offered together, each dropped when taken
  task automatic wr(input logic [7:0] idx, input logic [31:0] v,
                    input logic [1:0] er);
    @(posedge aclk);
    awaddr <= {22'h0, idx, 2'h0};
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, bresp});
  endtask
  task automatic rd(input logic [7:0] idx, input logic [31:0] ed,
                    input logic [1:0] er);
    @(posedge aclk);
    araddr <= {22'h0, idx, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk("rresp", {30'h0, er}, {30'h0, rresp});
    chk("rdata", ed, rdata);
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // ****************************
  // clock and watchdog
  // ****************************
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  // a hang ends here instead of running forever
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_total++;
      test_done;
    end
  end
  // ****************************
  // main sequence
  // ****************************
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, raw, den} = 8'h00;
    awaddr = 32'h0;
    wdata = 32'h0;
    araddr = 32'h0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    for (i = 8; i < 12; i++) rd(i[7:0], 32'h0, RESP_OKAY);
    rd(8'h0C, 32'h0, RESP_SLVERR);
    wr(8'h0D, 32'h1, RESP_SLVERR);
    // every margin code; reserved one keeps the old value
    for (i = 0; i < 4; i++) begin
      wr(IDX_MARGIN_CTRL, i, RESP_OKAY);
      rd(IDX_MARGIN_CTRL, (i == 3) ? 2 : i, RESP_OKAY);
    end
    chk("margin", 32'h2, {30'h0, margin});
    // every select code in both directions, enable drawn at random
    for (i = 0; i < 8; i++) begin
      sel = i[2:1];
      fall = i[0];
      d = $random(seed);
      ie = d[0];
      den <= 1'b0;
      raw <= !fall;
      wr(IDX_IRQ_FLAGS, 32'h1, RESP_OKAY);
      wr(IDX_IRQ_CTRL, {29'h0, sel, ie}, RESP_OKAY);
      den <= 1'b1;
      @(posedge aclk);
      raw <= fall;
      repeat (6) @(posedge aclk);
      e = exp_hit(sel, fall);
      rd(IDX_IRQ_FLAGS, {31'h0, e}, RESP_OKAY);
      chk("irq", {31'h0, e & ie}, {31'h0, irq});
      rd(IDX_LEVEL_STAT, {31'h0, fall}, RESP_OKAY);
    end
    // detector off: crossings ignored, flag kept
    wr(IDX_IRQ_FLAGS, 32'h1, RESP_OKAY);
    wr(IDX_IRQ_CTRL, {29'h0, CROSS_BOTH, 1'b1}, RESP_OKAY);
    den <= 1'b0;
    raw <= ~raw;
    repeat (6) @(posedge aclk);
    rd(IDX_IRQ_FLAGS, 32'h0, RESP_OKAY);
    den <= 1'b1;
    raw <= ~raw;
    repeat (6) @(posedge aclk);
    chk("irq", 32'h1, {31'h0, irq});
    // mask and unmask with the flag still set; irq lags one edge
    wr(IDX_IRQ_CTRL, {29'h0, CROSS_BOTH, 1'b0}, RESP_OKAY);
    @(posedge aclk);
    chk("irq", 32'h0, {31'h0, irq});
    wr(IDX_IRQ_CTRL, {29'h0, CROSS_BOTH, 1'b1}, RESP_OKAY);
    @(posedge aclk);
    chk("irq", 32'h1, {31'h0, irq});
    den <= 1'b0;
    wr(IDX_IRQ_FLAGS, 32'h0, RESP_OKAY);
    rd(IDX_IRQ_FLAGS, 32'h1, RESP_OKAY);
    wr(IDX_IRQ_FLAGS, 32'h1, RESP_OKAY);
    rd(IDX_IRQ_FLAGS, 32'h0, RESP_OKAY);
    chk("irq", 32'h0, {31'h0, irq});
    // random register traffic, writes to read-only status must leave it unchanged
    mexp = 2'h2;
    // status is only read with the detector on, level held steady
    den <= 1'b1;
    repeat (16) begin
      d = $random(seed);
      wr(IDX_IRQ_CTRL, d, RESP_OKAY);
      rd(IDX_IRQ_CTRL, {29'h0, d[2:0]}, RESP_OKAY);
      wr(IDX_MARGIN_CTRL, d, RESP_OKAY);
      if (d[1:0] != 2'h3) mexp = d[1:0];
      rd(IDX_MARGIN_CTRL, {30'h0, mexp}, RESP_OKAY);
      wr(IDX_LEVEL_STAT, d, RESP_OKAY);
      rd(IDX_LEVEL_STAT, {31'h0, raw}, RESP_OKAY);
    end
    test_done;
  end
endmodule
`default_nettype wire
